// *** rtl/canopen_node.v ***
// sync, emergency and sdo server layer of a canopen slave node
`timescale 1ns/1ps
`include "canopen_node_regs.vh"
module canopen_node (
	input  wire        clock,
	input  wire        rst,
	input  wire [6:0]  station_number,
	input  wire        rx_valid,
	input  wire [10:0] rx_id,
	input  wire [3:0]  rx_dlc,
	input  wire [63:0] rx_data,
	input  wire        tx_ready,
	output reg         tx_valid,
	output reg  [10:0] tx_id,
	output reg  [3:0]  tx_dlc,
	output reg  [63:0] tx_data,
	input  wire        fault_event,
	input  wire [1:0]  fault_kind,
	input  wire [7:0]  fault_class,
	input  wire [15:0] fault_code,
	input  wire [31:0] fault_aux,
	input  wire        fault_clear,
	input  wire        rpdo_load,
	input  wire [63:0] rpdo_data,
	output reg         rpdo_app_strobe,
	output reg  [63:0] rpdo_app_data,
	input  wire [7:0]  tpdo_type,
	input  wire [3:0]  tpdo_id_base,
	input  wire [3:0]  tpdo_dlc,
	input  wire [63:0] tpdo_data,
	input  wire        tpdo_data_changed,
	output reg         sync_pulse
);
	// ****************************************
	// object dictionary storage
	// ****************************************
	reg  [7:0]  error_summary;
	reg  [31:0] error_history [0:`HISTORY_DEPTH-1];
	reg  [2:0]  history_count;
	reg  [31:0] sync_identifier;
	reg  [31:0] sync_period;
	reg  [31:0] emergency_identifier;
	reg  [15:0] last_drive_error_code;
	// ****************************************
	// sync generation and consumption
	// ****************************************
	wire        us_tick;
	wire        period_hit;
	wire        tpdo_count_hit;
	wire        gen_active;
	wire        rx_sync;
	wire        sync_event;
	wire        tpdo_cyclic;
	wire [7:0]  tick_limit;

	// clocks per microsecond, cut to the divider width on purpose
	localparam [31:0] TICK_WIDE = `TICK_CYCLES;
	assign tick_limit = TICK_WIDE[7:0];
	assign gen_active  = sync_identifier[`SYNC_GEN_BIT] && (sync_period >= `SYNC_MIN_PERIOD_US);
	assign rx_sync     = rx_valid && (rx_id == sync_identifier[10:0]);
	assign sync_event  = rx_sync || (period_hit && gen_active);
	assign tpdo_cyclic = (tpdo_type != 8'h00) && (tpdo_type <= `TPDO_TYPE_MAX);

	tick_counter #(.W(8)) us_divider (
		.clock  (clock),
		.rst    (rst),
		.enable (1'b1),
		.step   (1'b1),
		.limit  (tick_limit),
		.hit    (us_tick)
	);

	tick_counter #(.W(32)) sync_timer (
		.clock  (clock),
		.rst    (rst),
		.enable (gen_active),
		.step   (us_tick),
		.limit  (sync_period),
		.hit    (period_hit)
	);

	tick_counter #(.W(8)) tpdo_sync_count (
		.clock  (clock),
		.rst    (rst),
		.enable (tpdo_cyclic),
		.step   (sync_event),
		.limit  (tpdo_type),
		.hit    (tpdo_count_hit)
	);

	// ****************************************
	// object lookup
	// ****************************************
	reg         seg_active;
	reg         seg_toggle;
	reg  [15:0] seg_index;
	reg  [7:0]  seg_sub;
	reg  [31:0] seg_value;
	reg  [3:0]  seg_count;
	wire [7:0]  req_cmd;
	wire [2:0]  req_ccs;
	wire [15:0] req_index;
	wire [7:0]  req_sub;
	wire [31:0] req_value;
	wire        sdo_req;
	wire [15:0] lk_index;
	wire [7:0]  lk_sub;
	reg         obj_ok;
	reg         obj_sub_ok;
	reg         obj_wr;
	reg  [2:0]  obj_len;
	reg  [31:0] obj_val;

	assign req_cmd   = rx_data[7:0];
	assign req_ccs   = rx_data[7:5];
	assign req_index = rx_data[23:8];
	assign req_sub   = rx_data[31:24];
	assign req_value = rx_data[63:32];
	assign sdo_req   = rx_valid && (rx_id == `SDO_RX_BASE + {4'h0, station_number}) && (rx_dlc == `FRAME_DLC);
	assign lk_index  = (req_ccs == `CCS_DL_SEG) ? seg_index : req_index;
	assign lk_sub    = (req_ccs == `CCS_DL_SEG) ? seg_sub : req_sub;

	always @* begin
		obj_ok     = 1'b1;
		obj_sub_ok = (lk_sub == 8'h00);
		obj_wr     = 1'b0;
		obj_len    = 3'h4;
		obj_val    = 32'h00000000;
		case (lk_index)
			`OBJ_ERROR_SUMMARY: begin
				obj_len = 3'h1;
				obj_val = {24'h000000, error_summary};
			end
			`OBJ_ERROR_HISTORY: begin
				obj_sub_ok = (lk_sub <= `HISTORY_DEPTH);
				if (lk_sub == 8'h00) begin
					obj_wr  = 1'b1;
					obj_len = 3'h1;
					obj_val = {29'h00000000, history_count};
				end else if (obj_sub_ok) begin
					obj_val = error_history[lk_sub[1:0] - 2'h1];
				end
			end
			`OBJ_SYNC_ID: begin
				obj_wr  = 1'b1;
				obj_val = sync_identifier;
			end
			`OBJ_SYNC_PERIOD: begin
				obj_wr  = 1'b1;
				obj_val = sync_period;
			end
			`OBJ_EMCY_ID: begin
				obj_wr  = 1'b1;
				obj_val = emergency_identifier;
			end
			`OBJ_DRIVE_ERROR: begin
				obj_len = 3'h2;
				obj_val = {16'h0000, last_drive_error_code};
			end
			default: obj_ok = 1'b0;
		endcase
	end

	// ****************************************
	// sdo request decode
	// ****************************************
	reg  [31:0] abort_code;
	reg  [63:0] next_resp;
	reg         resp_send;
	reg         wr_en;
	reg  [31:0] wr_val;
	reg  [2:0]  wr_len;
	reg         next_seg_active;
	reg         next_seg_toggle;
	reg  [31:0] next_seg_value;
	reg  [3:0]  next_seg_count;
	reg  [4:0]  seg_total;
	reg  [3:0]  seg_n;
	reg  [1:0]  up_gap;
	integer     i;

	always @* begin
		abort_code      = 32'h00000000;
		next_resp       = 64'h0;
		resp_send       = sdo_req;
		wr_en           = 1'b0;
		wr_val          = req_value;
		wr_len          = 3'h4 - {1'b0, req_cmd[3:2]};
		next_seg_active = seg_active;
		next_seg_toggle = seg_toggle;
		next_seg_value  = seg_value;
		next_seg_count  = seg_count;
		seg_n           = 4'h7 - {1'b0, req_cmd[3:1]};
		seg_total       = {1'b0, seg_count} + {1'b0, seg_n};
		up_gap          = 2'h0;
		case (req_ccs)
			`CCS_UL_INIT: begin
				if (!obj_ok)
					abort_code = `ABORT_NO_OBJECT;
				else if (!obj_sub_ok)
					abort_code = `ABORT_NO_SUB;
				else begin
					// unused byte count is four less the length, modulo four
					up_gap    = 2'h0 - obj_len[1:0];
					next_resp = {obj_val, req_sub, req_index, 4'h4, up_gap, 2'b11};
				end
			end
			`CCS_DL_INIT: begin
				next_seg_active = 1'b0;
				if (!obj_ok)
					abort_code = `ABORT_NO_OBJECT;
				else if (!obj_sub_ok)
					abort_code = `ABORT_NO_SUB;
				else if (!obj_wr)
					abort_code = `ABORT_READ_ONLY;
				else if (req_cmd[1]) begin
					if (req_cmd[0] && wr_len != obj_len)
						abort_code = `ABORT_LENGTH;
					else
						wr_en = 1'b1;
				end else begin
					next_seg_active = 1'b1;
					next_seg_toggle = 1'b0;
					next_seg_value  = 32'h00000000;
					next_seg_count  = 4'h0;
					next_resp       = {32'h00000000, req_sub, req_index, `RSP_DL_OK};
				end
			end
			`CCS_DL_SEG: begin
				if (!seg_active)
					abort_code = `ABORT_COMMAND;
				else if (req_cmd[4] != seg_toggle)
					abort_code = `ABORT_TOGGLE;
				else begin
					for (i = 0; i < 7; i = i + 1)
						if (i < seg_n && seg_count + i < 4)
							next_seg_value[(seg_count + i) * 8 +: 8] = rx_data[8 + i * 8 +: 8];
					next_seg_count  = seg_total[4] ? 4'hf : seg_total[3:0];
					next_seg_toggle = !seg_toggle;
					next_resp       = {56'h0, `RSP_SEG_OK | {3'h0, seg_toggle, 4'h0}};
					if (req_cmd[0]) begin
						next_seg_active = 1'b0;
						wr_val          = next_seg_value;
						wr_len          = next_seg_count[2:0];
						if (next_seg_count != {1'b0, obj_len})
							abort_code = `ABORT_LENGTH;
						else
							wr_en = 1'b1;
					end
				end
			end
			`CCS_ABORT: begin
				resp_send       = 1'b0;
				next_seg_active = 1'b0;
			end
			default: abort_code = `ABORT_COMMAND;
		endcase
		if (wr_en) begin
			if (lk_index == `OBJ_SYNC_PERIOD && wr_val != 32'h0 && wr_val < `SYNC_MIN_PERIOD_US)
				abort_code = `ABORT_TOO_LOW;
			else if (lk_index == `OBJ_ERROR_HISTORY && wr_val[7:0] != 8'h00)
				abort_code = `ABORT_VALUE;
			if (abort_code != 32'h0)
				wr_en = 1'b0;
			else if (req_ccs == `CCS_DL_INIT)
				next_resp = {32'h00000000, req_sub, req_index, `RSP_DL_OK};
		end
		if (abort_code != 32'h0) begin
			next_seg_active = 1'b0;
			next_resp       = {abort_code, req_sub, req_index, `RSP_ABORT};
		end
	end

	// ****************************************
	// dictionary writes and fault recording
	// ****************************************
	reg  [7:0]  next_summary;
	reg  [15:0] emcy_code;
	reg  [31:0] emcy_aux;
	reg  [63:0] emcy_frame;
	reg         emcy_set;
	integer     k;

	always @* begin
		next_summary = error_summary | fault_class | 8'h01;
		emcy_set     = fault_event && !emergency_identifier[`EMCY_OFF_BIT];
		case (fault_kind)
			`KIND_DRIVE: begin
				emcy_code = fault_code;
				emcy_aux  = fault_aux;
			end
			`KIND_USER: begin
				emcy_code = `EMCY_USER_CODE;
				emcy_aux  = fault_aux;
			end
			default: begin
				emcy_code = fault_code;
				emcy_aux  = 32'h00000000;
			end
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			error_summary         <= 8'h00;
			history_count         <= 3'h0;
			sync_identifier       <= `SYNC_ID_RESET;
			sync_period           <= `SYNC_PERIOD_RESET;
			emergency_identifier  <= `EMCY_ID_RESET;
			last_drive_error_code <= 16'h0000;
			emcy_frame            <= 64'h0;
			seg_active            <= 1'b0;
			seg_toggle            <= 1'b0;
			seg_index             <= 16'h0000;
			seg_sub               <= 8'h00;
			seg_value             <= 32'h00000000;
			seg_count             <= 4'h0;
			for (k = 0; k < `HISTORY_DEPTH; k = k + 1)
				error_history[k] <= 32'h00000000;
		end else begin
			if (sdo_req) begin
				seg_active <= next_seg_active;
				seg_toggle <= next_seg_toggle;
				seg_value  <= next_seg_value;
				seg_count  <= next_seg_count;
				if (req_ccs == `CCS_DL_INIT) begin
					seg_index <= req_index;
					seg_sub   <= req_sub;
				end
			end
			if (sdo_req && wr_en) begin
				case (lk_index)
					`OBJ_SYNC_ID:     sync_identifier      <= wr_val;
					`OBJ_SYNC_PERIOD: sync_period          <= wr_val;
					`OBJ_EMCY_ID:     emergency_identifier <= wr_val;
					default:          history_count        <= 3'h0;
				endcase
			end
			if (fault_clear && !fault_event)
				error_summary <= 8'h00;
			if (fault_event) begin
				error_summary <= next_summary;
				error_history[0] <= {fault_aux[15:0], emcy_code};
				for (k = 1; k < `HISTORY_DEPTH; k = k + 1)
					error_history[k] <= error_history[k-1];
				if (history_count < `HISTORY_DEPTH)
					history_count <= history_count + 3'h1;
				if (fault_kind == `KIND_DRIVE)
					last_drive_error_code <= fault_code;
				emcy_frame <= {emcy_aux, 8'h00, next_summary, emcy_code};
			end
		end
	end

	// ****************************************
	// pdo timing and frame transmission
	// ****************************************
	reg         rpdo_held;
	reg  [63:0] rpdo_buffer;
	reg         tpdo_changed;
	reg         sync_pending;
	reg         emcy_pending;
	reg         tpdo_pending;
	reg         sdo_pending;
	reg  [63:0] sdo_resp;
	wire        tx_free;
	wire        grant_sync;
	wire        grant_emcy;
	wire        grant_tpdo;
	wire        grant_sdo;
	wire        tpdo_set;

	assign tx_free    = !tx_valid || tx_ready;
	assign grant_sync = tx_free && sync_pending;
	assign grant_emcy = tx_free && !sync_pending && emcy_pending;
	assign grant_tpdo = tx_free && !sync_pending && !emcy_pending && tpdo_pending;
	assign grant_sdo  = tx_free && !sync_pending && !emcy_pending && !tpdo_pending && sdo_pending;
	assign tpdo_set   = (tpdo_type == 8'h00) ? (sync_event && tpdo_changed) : tpdo_count_hit;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rpdo_held       <= 1'b0;
			rpdo_buffer     <= 64'h0;
			rpdo_app_strobe <= 1'b0;
			rpdo_app_data   <= 64'h0;
			tpdo_changed    <= 1'b0;
			sync_pending    <= 1'b0;
			emcy_pending    <= 1'b0;
			tpdo_pending    <= 1'b0;
			sdo_pending     <= 1'b0;
			sdo_resp        <= 64'h0;
			sync_pulse      <= 1'b0;
			tx_valid        <= 1'b0;
			tx_id           <= 11'h000;
			tx_dlc          <= 4'h0;
			tx_data         <= 64'h0;
		end else begin
			sync_pulse      <= sync_event;
			rpdo_app_strobe <= 1'b0;
			if (rpdo_load) begin
				rpdo_held   <= 1'b1;
				rpdo_buffer <= rpdo_data;
			end
			if (sync_event && rpdo_held) begin
				rpdo_app_strobe <= 1'b1;
				rpdo_app_data   <= rpdo_buffer;
				rpdo_held       <= rpdo_load;
			end
			tpdo_changed <= tpdo_data_changed || (tpdo_changed && !(tpdo_type == 8'h00 && sync_event));
			sync_pending <= (period_hit && gen_active) || (sync_pending && !grant_sync);
			emcy_pending <= emcy_set || (emcy_pending && !grant_emcy);
			tpdo_pending <= tpdo_set || (tpdo_pending && !grant_tpdo);
			sdo_pending  <= (sdo_req && resp_send) || (sdo_pending && !grant_sdo);
			if (sdo_req && resp_send)
				sdo_resp <= next_resp;
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			if (grant_sync) begin
				tx_valid <= 1'b1;
				tx_id    <= sync_identifier[10:0];
				tx_dlc   <= 4'h0;
				tx_data  <= 64'h0;
			end else if (grant_emcy) begin
				tx_valid <= 1'b1;
				tx_id    <= `EMCY_BASE + {4'h0, station_number};
				tx_dlc   <= `FRAME_DLC;
				tx_data  <= emcy_frame;
			end else if (grant_tpdo) begin
				tx_valid <= 1'b1;
				tx_id    <= {tpdo_id_base, station_number};
				tx_dlc   <= tpdo_dlc;
				tx_data  <= tpdo_data;
			end else if (grant_sdo) begin
				tx_valid <= 1'b1;
				tx_id    <= `SDO_TX_BASE + {4'h0, station_number};
				tx_dlc   <= `FRAME_DLC;
				tx_data  <= sdo_resp;
			end
		end
	end
endmodule

// *** include/canopen_node_regs.vh ***
// object dictionary indices, field positions, codes and timing counts of the node
`ifndef CANOPEN_NODE_REGS_VH
`define CANOPEN_NODE_REGS_VH
// ****************************************
// object indices
// ****************************************
`define OBJ_ERROR_SUMMARY   16'h1001
`define OBJ_ERROR_HISTORY   16'h1003
`define OBJ_SYNC_ID         16'h1005
`define OBJ_SYNC_PERIOD     16'h1006
`define OBJ_EMCY_ID         16'h1014
`define OBJ_DRIVE_ERROR     16'h603f
// ****************************************
// reset values and field positions
// ****************************************
`define SYNC_ID_RESET       32'h00000080
`define SYNC_PERIOD_RESET   32'h00000000
`define EMCY_ID_RESET       32'h00000000
`define SYNC_GEN_BIT        30
`define EMCY_OFF_BIT        31
`define HISTORY_DEPTH       4
`define TPDO_TYPE_MAX       8'hf0
// ****************************************
// frame identifiers
// ****************************************
`define SDO_RX_BASE         11'h600
`define SDO_TX_BASE         11'h580
`define EMCY_BASE           11'h080
`define FRAME_DLC           4'h8
// ****************************************
// sdo command specifiers and replies
// ****************************************
`define CCS_DL_SEG          3'h0
`define CCS_DL_INIT         3'h1
`define CCS_UL_INIT         3'h2
`define CCS_ABORT           3'h4
`define RSP_DL_OK           8'h60
`define RSP_SEG_OK          8'h20
`define RSP_ABORT           8'h80
`define ABORT_TOGGLE        32'h05030000
`define ABORT_COMMAND       32'h05040001
`define ABORT_READ_ONLY     32'h06010002
`define ABORT_NO_OBJECT     32'h06020000
`define ABORT_LENGTH        32'h06070010
`define ABORT_NO_SUB        32'h06090011
`define ABORT_VALUE         32'h06090030
`define ABORT_TOO_LOW       32'h06090032
// ****************************************
// emergency codes
// ****************************************
`define EMCY_USER_CODE      16'hff00
`define KIND_COMM           2'h0
`define KIND_DRIVE          2'h1
`define KIND_USER           2'h2
// ****************************************
// timing
// ****************************************
`define CLOCK_PERIOD_NS     8
`define TICK_TIME_NS        1000
`define TICK_CYCLES         (`TICK_TIME_NS / `CLOCK_PERIOD_NS)
`define SYNC_MIN_PERIOD_US  500
`endif

// *** rtl/tick_counter.v ***
// step counter that pulses once every limit steps
`timescale 1ns/1ps
module tick_counter #(
	parameter W = 8
) (
	input  wire         clock,
	input  wire         rst,
	input  wire         enable,
	input  wire         step,
	input  wire [W-1:0] limit,
	output reg          hit
);
	reg [W-1:0] count;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= {W{1'b0}};
			hit   <= 1'b0;
		end else begin
			hit <= 1'b0;
			if (!enable) begin
				count <= {W{1'b0}};
			end else if (step) begin
				if ({1'b0, count} + {{W{1'b0}}, 1'b1} >= {1'b0, limit}) begin
					count <= {W{1'b0}};
					hit   <= 1'b1;
				end else begin
					count <= count + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// *** sim/canopen_node_props.sv ***
// assertions on the frame, sync and pdo ports of the node
`timescale 1ns/1ps
module canopen_node_props (
	input wire        clock,
	input wire        rst,
	input wire [6:0]  station_number,
	input wire        rx_valid,
	input wire [10:0] rx_id,
	input wire [3:0]  rx_dlc,
	input wire        tx_valid,
	input wire [10:0] tx_id,
	input wire [3:0]  tx_dlc,
	input wire [63:0] tx_data,
	input wire        rpdo_app_strobe,
	input wire [63:0] rpdo_app_data,
	input wire [3:0]  tpdo_id_base,
	input wire        sync_pulse
);
	// ****************************************
	// sequences and properties
	// ****************************************
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_rx_sync;
		rx_valid && rx_id == 11'h080 && rx_dlc == 4'h0;
	endsequence
	sequence s_no_reply;
		(!tx_valid || tx_id != {4'hb, station_number}) [*4];
	endsequence
	property p_sync_event;
		s_rx_sync |-> ##[1:2] sync_pulse;
	endproperty
	property p_sync_silent;
		s_rx_sync |=> s_no_reply;
	endproperty
	property p_sdo_reply;
		tx_valid && tx_id[10:7] == 4'hb |-> tx_id[6:0] == station_number && tx_dlc == 4'h8;
	endproperty
	property p_emcy_frame;
		tx_valid && tx_id == {4'h1, station_number} |-> tx_dlc == 4'h8 && tx_data[31:24] == 8'h00;
	endproperty
	property p_sync_frame;
		tx_valid && tx_id == 11'h080 |-> tx_dlc == 4'h0;
	endproperty
	property p_tpdo_id;
		tx_valid && tx_id[10:7] == tpdo_id_base |-> tx_id[6:0] == station_number;
	endproperty
	property p_rpdo_gate;
		rpdo_app_strobe |-> sync_pulse || $past(sync_pulse);
	endproperty
	property p_rpdo_data;
		!$stable(rpdo_app_data) |-> rpdo_app_strobe;
	endproperty
	property p_foreign_emcy;
		rx_valid && rx_id[10:7] == 4'h1 && rx_id[6:0] != 7'h00 |=> !sync_pulse [*2];
	endproperty
	a_sync_event: assert property (p_sync_event) else $error("no sync pulse");
	a_sync_silent: assert property (p_sync_silent) else $error("reply to sync");
	a_sdo_reply: assert property (p_sdo_reply) else $error("bad reply frame");
	a_emcy_frame: assert property (p_emcy_frame) else $error("bad emcy frame");
	a_sync_frame: assert property (p_sync_frame) else $error("bad sync frame");
	a_tpdo_id: assert property (p_tpdo_id) else $error("bad tpdo id");
	a_rpdo_gate: assert property (p_rpdo_gate) else $error("rpdo off sync");
	a_rpdo_data: assert property (p_rpdo_data) else $error("rpdo data moved");
	a_foreign_emcy: assert property (p_foreign_emcy) else $error("emcy consumed");
endmodule
bind canopen_node canopen_node_props u_props (
	.clock, .rst, .station_number, .rx_valid, .rx_id, .rx_dlc, .tx_valid, .tx_id, .tx_dlc,
	.tx_data, .rpdo_app_strobe, .rpdo_app_data, .tpdo_id_base, .sync_pulse
);

// *** sim/can_master_model.sv ***
// bus master model: sends request frames and takes the node's frames
`timescale 1ns/1ps
module can_master_model (
	input  wire        clock,
	input  wire        rst,
	input  wire [6:0]  station_number,
	output reg         rx_valid,
	output reg  [10:0] rx_id,
	output reg  [3:0]  rx_dlc,
	output reg  [63:0] rx_data,
	output reg         tx_ready,
	input  wire        tx_valid,
	input  wire [10:0] tx_id,
	input  wire [3:0]  tx_dlc,
	input  wire [63:0] tx_data
);
	logic [78:0] got_q[$];
	initial begin
		rx_valid = 1'b0;
		rx_id = 11'h7ff;
		rx_dlc = 4'h0;
		rx_data = 64'h0;
		tx_ready = 1'b0;
	end
	// ****************************************
	// frame intake with random stalls
	// ****************************************
	always @(negedge clock)
		tx_ready <= ($urandom % 3) != 0;
	always @(posedge clock)
		if (!rst && tx_valid && tx_ready)
			got_q.push_back({tx_id, tx_dlc, tx_data});
	// released data lines show the inverse, never the stale frame
	task send(input [10:0] id, input [3:0] dlc, input [63:0] data);
		@(negedge clock);
		rx_valid = 1'b1;
		rx_id = id;
		rx_dlc = dlc;
		rx_data = data;
		@(negedge clock);
		rx_valid = 1'b0;
		rx_data = ~data;
	endtask
	// len is the byte count less one
	task sdo_write(input [15:0] idx, input [7:0] sub, input [31:0] val, input [1:0] len);
		send({4'hc, station_number}, 4'h8, {val, sub, idx, 8'h23 | ((8'd3 - len) << 2)});
	endtask
	task sdo_read(input [15:0] idx, input [7:0] sub);
		send({4'hc, station_number}, 4'h8, {32'h0, sub, idx, 8'h40});
	endtask
endmodule

// *** sim/canopen_node_tb.sv ***
// self-checking bench of the sync, emergency and sdo node layer
`timescale 1ns/1ps
`include "canopen_node_regs.vh"
module canopen_node_tb;
	logic        clock, rst, rx_valid, tx_ready, tx_valid, rpdo_load, rpdo_app_strobe;
	logic        fault_event, fault_clear, tpdo_data_changed, sync_pulse;
	logic [6:0]  station_number;
	logic [10:0] rx_id, tx_id;
	logic [3:0]  rx_dlc, tx_dlc, tpdo_id_base, tpdo_dlc;
	logic [1:0]  fault_kind;
	logic [7:0]  fault_class, tpdo_type, er;
	logic [15:0] fault_code;
	logic [31:0] fault_aux;
	logic [63:0] rx_data, tx_data, rpdo_data, rpdo_app_data, tpdo_data;
	int          num_errors, tests_run, cycles, syncs, i, n_type;
	canopen_node u_dut (
		.clock, .rst, .station_number, .rx_valid, .rx_id, .rx_dlc, .rx_data, .tx_ready,
		.tx_valid, .tx_id, .tx_dlc, .tx_data, .fault_event, .fault_kind, .fault_class,
		.fault_code, .fault_aux, .fault_clear, .rpdo_load, .rpdo_data, .rpdo_app_strobe,
		.rpdo_app_data, .tpdo_type, .tpdo_id_base, .tpdo_dlc, .tpdo_data,
		.tpdo_data_changed, .sync_pulse
	);
	can_master_model u_master (
		.clock, .rst, .station_number, .rx_valid, .rx_id, .rx_dlc, .rx_data, .tx_ready,
		.tx_valid, .tx_id, .tx_dlc, .tx_data
	);
	// ****************************************
	// clock, watchdog and helpers
	// ****************************************
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (!rst && sync_pulse === 1'b1)
			syncs++;
		if (cycles == 90000) begin
			num_errors++;
			complete_run;
		end
	end
	task complete_run;
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string what, input [78:0] exp, input [78:0] seen);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task frame(input string what, input [78:0] exp, input [78:0] mask);
		int n;
		n = 0;
		while (u_master.got_q.size() == 0 && n < 64000) begin
			@(posedge clock);
			n++;
		end
		chk(what, exp & mask, (u_master.got_q.size() != 0) ? u_master.got_q.pop_front() & mask : 'x);
	endtask
	task quiet(input string what);
		repeat (12) @(posedge clock);
		chk(what, 79'd0, 79'(u_master.got_q.size()));
	endtask
	task sync_rx;
		u_master.send(11'h080, 4'h0, 64'h0);
		repeat (3) @(posedge clock);
	endtask
	task fault(input [1:0] kind);
		@(negedge clock);
		{fault_class, fault_code, fault_aux} = 56'({$urandom, $urandom});
		fault_kind = kind;
		fault_event = 1'b1;
		@(negedge clock);
		fault_event = 1'b0;
		er = er | fault_class | 8'h01;
	endtask
	function automatic [78:0] rsp(input [63:0] d);
		rsp = {4'hb, station_number, 4'h8, d};
	endfunction
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		void'($urandom(54355));
		station_number = 7'($urandom_range(126, 1));
		n_type = $urandom_range(4, 2);
		tpdo_type = 8'(n_type);
		tpdo_id_base = 4'h3;
		tpdo_dlc = 4'h8;
		tpdo_data = {$urandom, $urandom};
		rpdo_data = {$urandom, $urandom};
		{rpdo_load, tpdo_data_changed, fault_event, fault_clear, er} = 12'h0;
		{fault_kind, fault_class, fault_code, fault_aux} = 58'h0;
		repeat (12) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		rpdo_load = 1'b1;
		@(negedge clock);
		rpdo_load = 1'b0;
		repeat (3) @(posedge clock);
		chk("rpdo held", 79'(64'h0), 79'(rpdo_app_data));
		for (i = 1; i <= n_type; i++) begin
			sync_rx;
			if (i == 1)
				chk("rpdo delivered", 79'(rpdo_data), 79'(rpdo_app_data));
			if (i < n_type)
				quiet("tpdo early");
		end
		frame("tpdo cyclic", {tpdo_id_base, station_number, tpdo_dlc, tpdo_data}, '1);
		chk("sync count", 79'(n_type), 79'(syncs));
		@(negedge clock);
		tpdo_type = 8'h00;
		sync_rx;
		quiet("tpdo unchanged");
		@(negedge clock);
		tpdo_data = ~tpdo_data;
		tpdo_data_changed = 1'b1;
		@(negedge clock);
		tpdo_data_changed = 1'b0;
		sync_rx;
		frame("tpdo changed", {tpdo_id_base, station_number, tpdo_dlc, tpdo_data}, '1);
		u_master.sdo_read(`OBJ_SYNC_ID, 8'h00);
		frame("sync id", rsp({32'h80, 32'h00100543}), '1);
		for (i = 0; i < 3; i++) begin
			u_master.sdo_write(`OBJ_SYNC_PERIOD, 8'h00, 32'd700, 2'(i));
			frame("length abort", rsp({`ABORT_LENGTH, 32'h00100680}), '1);
		end
		u_master.sdo_write(`OBJ_SYNC_PERIOD, 8'h00, 32'd499, 2'd3);
		frame("period low", rsp({`ABORT_TOO_LOW, 32'h00100680}), '1);
		u_master.sdo_write(`OBJ_SYNC_PERIOD, 8'h00, 32'd500, 2'd3);
		frame("period set", rsp({32'h0, 32'h00100660}), '1);
		u_master.sdo_write(`OBJ_SYNC_ID, 8'h00, 32'h40000080, 2'd3);
		frame("gen on", rsp({32'h0, 32'h00100560}), '1);
		frame("sync gen", {11'h080, 4'h0, 64'h0}, {15'h7fff, 64'h0});
		u_master.sdo_write(`OBJ_SYNC_ID, 8'h00, 32'h00000080, 2'd3);
		frame("gen off", rsp({32'h0, 32'h00100560}), '1);
		u_master.send({4'hc, station_number}, 4'h8, {32'h4, 8'h00, `OBJ_SYNC_PERIOD, 8'h21});
		frame("seg init", rsp({32'h0, 32'h00100660}), '1);
		u_master.send({4'hc, station_number}, 4'h8, {24'h0, 32'd600, 8'h07});
		frame("seg last", rsp({32'h0, 32'h00000020}), '1);
		u_master.sdo_read(`OBJ_SYNC_PERIOD, 8'h00);
		frame("seg value", rsp({32'd600, 32'h00100643}), '1);
		for (i = 0; i < 3; i++) begin
			fault(2'(i));
			frame("emcy", {4'h1, station_number, 4'h8, (i == 0) ? 32'h0 : fault_aux, 8'h00, er,
				(i == 2) ? `EMCY_USER_CODE : fault_code}, '1);
		end
		u_master.sdo_write(`OBJ_EMCY_ID, 8'h00, 32'h80000000, 2'd3);
		frame("emcy off", rsp({32'h0, 32'h00101460}), '1);
		fault(`KIND_DRIVE);
		quiet("emcy silent");
		u_master.sdo_read(`OBJ_ERROR_SUMMARY, 8'h00);
		frame("err reg", rsp({24'h0, er, 32'h0010014f}), '1);
		u_master.sdo_read(`OBJ_ERROR_HISTORY, 8'h01);
		frame("newest", rsp({fault_aux[15:0], fault_code, 32'h01100343}), '1);
		u_master.sdo_read(`OBJ_ERROR_HISTORY, 8'h00);
		frame("entries", rsp({32'h4, 32'h0010034f}), '1);
		u_master.sdo_read(`OBJ_DRIVE_ERROR, 8'h00);
		frame("drive code", rsp({16'h0, fault_code, 32'h00603f4b}), '1);
		u_master.send({4'h1, ~station_number}, 4'h8, {$urandom, $urandom});
		quiet("foreign emcy");
		complete_run;
	end
endmodule
